// >>> common/wkp_defs.vh
/*
 Constants for the watchdog and keep-alive power control block.
 Assumes a 100 MHz clock; included by bare name.
*/
`ifndef WKP_DEFS_VH
`define WKP_DEFS_VH

// ==========================================================
// Timing
// ==========================================================
`define WKP_CLK_PERIOD_NS   10
`define WKP_TRIG_MIN_US     10
`define WKP_TRIG_MIN_CYC    ((`WKP_TRIG_MIN_US * 1000 + `WKP_CLK_PERIOD_NS - 1) / `WKP_CLK_PERIOD_NS)
`define WKP_WD_TERM_CYC     5000000
`define WKP_WD_START_CYC    20
`define WKP_DLY_TERM_CYC    5000000
`define WKP_DLY_START_CYC   20
`define WKP_OFF_DROP_CYC    4

// ==========================================================
// Reset values
// ==========================================================
`define WKP_RST_N_RESET     1'b0
`define WKP_OUT_EN_RESET    1'b0

`endif

// >>> core/wkp_ramp.v
/*
 Ramp counter standing in for a charged timing capacitor.
 Assumes a single clock; clear forces the count back to zero, below the start level.
*/
`timescale 1ns/1ns
`default_nettype none

module wkp_ramp #(
  parameter integer START_CYC = 20,
  parameter integer TERM_CYC  = 5000000,
  parameter integer W         = 24
) (
  input  wire         clk,
  input  wire         reset,
  input  wire         clear,
  input  wire         run,
  output wire         at_start,
  output wire         at_term
);

  reg [W-1:0] cnt_q;

  // ========================================================
  // Counter
  // ========================================================
  always @(posedge clk) begin
    if (reset || clear) begin
      cnt_q <= {W{1'b0}};
    end else if (run && !at_term) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign at_start = (cnt_q >= START_CYC[W-1:0]);
  assign at_term  = (cnt_q >= TERM_CYC[W-1:0]);

endmodule // wkp_ramp

`default_nettype wire

// >>> core/wkp_top.v
/*
 Watchdog and keep-alive power control logic of a dual-output regulator.
 Assumes pins from outside the clock domain; main_in_reg comes from the
 supply monitor; strap level sampled every cycle after reset release.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wkp_defs.vh"

module wkp_top #(
  parameter integer WD_TERM_CYC  = `WKP_WD_TERM_CYC,
  parameter integer WD_START_CYC = `WKP_WD_START_CYC,
  parameter integer DLY_TERM_CYC = `WKP_DLY_TERM_CYC,
  parameter integer DLY_START_CYC= `WKP_DLY_START_CYC,
  parameter integer TRIG_MIN_CYC = `WKP_TRIG_MIN_CYC,
  parameter integer CNT_W        = 24
) (
  input  wire         clk,
  input  wire         reset,
  input  wire         on_off_in,
  input  wire         keep_alive_in,
  input  wire         wd_trigger_in,
  input  wire         wd_strap_disable_in,
  input  wire         main_in_reg,
  output wire         out_enable,
  output wire         sys_reset_n,
  output wire         wd_disabled
);

  // ========================================================
  // Input synchronisers
  // ========================================================
  reg [1:0] on_sync_q;
  reg [1:0] ka_sync_q;
  reg [1:0] trg_sync_q;
  reg [1:0] strap_sync_q;
  reg [1:0] reg_sync_q;

  always @(posedge clk) begin
    if (reset) begin
      on_sync_q    <= 2'h0;
      ka_sync_q    <= 2'h0;
      trg_sync_q   <= 2'h0;
      strap_sync_q <= 2'h0;
      reg_sync_q   <= 2'h0;
    end else begin
      on_sync_q    <= {on_sync_q[0], on_off_in};
      ka_sync_q    <= {ka_sync_q[0], keep_alive_in};
      trg_sync_q   <= {trg_sync_q[0], wd_trigger_in};
      strap_sync_q <= {strap_sync_q[0], wd_strap_disable_in};
      reg_sync_q   <= {reg_sync_q[0], main_in_reg};
    end
  end

  wire on_s    = on_sync_q[1];
  wire ka_s    = ka_sync_q[1];
  wire trg_s   = trg_sync_q[1];
  wire strap_s = strap_sync_q[1];
  wire reg_s   = reg_sync_q[1];

  // ========================================================
  // Output enable
  // ========================================================
  reg out_en_q;

  always @(posedge clk) begin
    if (reset) begin
      out_en_q <= `WKP_OUT_EN_RESET;
    end else begin
      out_en_q <= on_s | ka_s;
    end
  end

  assign out_enable = out_en_q;

  // ========================================================
  // Main output settling
  // ========================================================
  // Main output drops out at once when disabled and needs a few cycles
  // to come back, so a brief off pulse still restarts the delay
  localparam [7:0] SETTLE_LOAD = `WKP_OFF_DROP_CYC;

  reg [7:0] settle_q;

  always @(posedge clk) begin
    if (reset) begin
      settle_q <= SETTLE_LOAD;
    end else if (!out_en_q) begin
      settle_q <= SETTLE_LOAD;
    end else if (settle_q != 8'h00) begin
      settle_q <= settle_q - 8'h01;
    end
  end

  // ========================================================
  // Strap capture
  // ========================================================
  reg wd_dis_q;

  always @(posedge clk) begin
    if (reset) begin
      wd_dis_q <= 1'b0;
    end else begin
      wd_dis_q <= strap_s;
    end
  end

  assign wd_disabled = wd_dis_q;

  // ========================================================
  // Trigger qualification and one-shot
  // ========================================================
  reg             trg_prev_q;
  reg             trg_armed_q;
  reg [CNT_W-1:0] trg_len_q;
  reg             one_shot_q;

  wire trg_rise = trg_s & ~trg_prev_q;

  always @(posedge clk) begin
    if (reset) begin
      trg_prev_q  <= 1'b0;
      trg_armed_q <= 1'b0;
      trg_len_q   <= {CNT_W{1'b0}};
      one_shot_q  <= 1'b0;
    end else begin
      trg_prev_q <= trg_s;
      one_shot_q <= 1'b0;
      if (trg_rise) begin
        trg_armed_q <= 1'b1;
        trg_len_q   <= {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (trg_s && trg_armed_q) begin
        if (trg_len_q >= TRIG_MIN_CYC[CNT_W-1:0] - 1) begin
          one_shot_q  <= 1'b1;
          trg_armed_q <= 1'b0;
        end else begin
          trg_len_q <= trg_len_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end else if (!trg_s) begin
        trg_armed_q <= 1'b0;
      end
    end
  end

  // ========================================================
  // Reset sequencer
  // ========================================================
  localparam [3:0] ST_OFF   = 4'h1;
  localparam [3:0] ST_DELAY = 4'h2;
  localparam [3:0] ST_RUN   = 4'h4;
  localparam [3:0] ST_WDRST = 4'h8;

  reg [3:0] st_q;
  reg [3:0] st_d;
  reg       rst_n_q;

  wire dly_term;
  wire wd_start;
  wire wd_term;
  reg  wd_latch_q;

  // Supply in regulation only while outputs enabled, settled and monitor good
  wire supply_ok = out_en_q & reg_s & (settle_q == 8'h00);

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_OFF: begin
        if (supply_ok) begin
          st_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!supply_ok) begin
          st_d = ST_OFF;
        end else if (dly_term) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!supply_ok) begin
          st_d = ST_OFF;
        end else if (wd_term && !wd_dis_q) begin
          st_d = ST_WDRST;
        end
      end
      ST_WDRST: begin
        st_d = ST_DELAY;
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      st_q    <= ST_OFF;
      rst_n_q <= `WKP_RST_N_RESET;
    end else begin
      st_q    <= st_d;
      rst_n_q <= (st_d == ST_RUN);
    end
  end

  assign sys_reset_n = rst_n_q;

  // ========================================================
  // Delay and watchdog ramps
  // ========================================================
  wire dly_clear = (st_q != ST_DELAY);

  wkp_ramp #(
    .START_CYC (DLY_START_CYC),
    .TERM_CYC  (DLY_TERM_CYC),
    .W         (CNT_W)
  ) u_dly (
    .clk      (clk),
    .reset    (reset),
    .clear    (dly_clear),
    .run      (1'b1),
    .at_start (),
    .at_term  (dly_term)
  );

  // Discharge latch holds until the start level is reached
  always @(posedge clk) begin
    if (reset) begin
      wd_latch_q <= 1'b0;
    end else if (one_shot_q) begin
      wd_latch_q <= 1'b1;
    end else if (wd_start) begin
      wd_latch_q <= 1'b0;
    end
  end

  wire wd_clear = !rst_n_q || wd_dis_q || (one_shot_q && !wd_latch_q);

  wkp_ramp #(
    .START_CYC (WD_START_CYC),
    .TERM_CYC  (WD_TERM_CYC),
    .W         (CNT_W)
  ) u_wd (
    .clk      (clk),
    .reset    (reset),
    .clear    (wd_clear),
    .run      (1'b1),
    .at_start (wd_start),
    .at_term  (wd_term)
  );

endmodule // wkp_top

`default_nettype wire

// >>> verif/wkp_props.sv
/* Checker on the wkp_top ports.
 Bound into each wkp_top; one clock. */
`timescale 1ns/1ns
`default_nettype none
module wkp_props #(
  parameter integer WD_TERM_CYC  = 200,
  parameter integer DLY_TERM_CYC = 200
) (
  input wire clk,
  input wire reset,
  input wire on_off_in,
  input wire keep_alive_in,
  input wire wd_trigger_in,
  input wire wd_strap_disable_in,
  input wire main_in_reg,
  input wire out_enable,
  input wire sys_reset_n,
  input wire wd_disabled
);
  // ==========
  // Checks
  int lo_n, hi_n;
  always @(posedge clk) lo_n <= (reset || sys_reset_n) ? 0 : lo_n + 1;
  always @(posedge clk) hi_n <= (reset || !sys_reset_n || wd_disabled || $rose(wd_trigger_in)) ? 0 : hi_n + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  rst_vals_a: assert property (disable iff (1'b0) reset |=> !out_enable && !sys_reset_n)
    else $error("on in reset");
  en_on_a: assert property ((on_off_in || keep_alive_in) [*6] |-> out_enable)
    else $error("off");
  en_off_a: assert property ((!on_off_in && !keep_alive_in) [*6] |-> !out_enable)
    else $error("on");
  off_rst_a: assert property (!out_enable [*3] |-> !sys_reset_n)
    else $error("no reset");
  mon_rst_a: assert property (!main_in_reg [*5] |-> !sys_reset_n)
    else $error("no reset");
  dly_hold_a: assert property ($rose(sys_reset_n) |-> lo_n >= DLY_TERM_CYC)
    else $error("delay short");
  wd_max_a: assert property (hi_n <= WD_TERM_CYC + 40)
    else $error("watchdog late");
  strap_on_a: assert property (wd_strap_disable_in [*6] |-> wd_disabled)
    else $error("strap ignored");
  cover property ($rose(sys_reset_n));
  cover property ($fell(sys_reset_n) && out_enable);
  cover property (wd_disabled && sys_reset_n);
endmodule // wkp_props
bind wkp_top wkp_props #(.WD_TERM_CYC(WD_TERM_CYC), .DLY_TERM_CYC(DLY_TERM_CYC)) u_props (.*);
`default_nettype wire

// >>> verif/wkp_mcu.sv
/* Controller model: trigger pulses and keep-alive.
 Sees the device reset pin. */
`timescale 1ns/1ns
`default_nettype none
module wkp_mcu #(
  parameter integer HI = 6
) (
  input  wire       clk,
  input  wire       sys_reset_n,
  input  wire       run,
  input  wire       stuck,
  input  wire       sense,
  input  wire [7:0] per,
  output wire       wd_trigger_in,
  output wire       keep_alive_in
);
  // ==========
  // Pulses
  logic [7:0] cnt_q;
  always @(posedge clk) cnt_q <= (!sys_reset_n || cnt_q >= per) ? 8'h00 : cnt_q + 8'h01;
  assign wd_trigger_in = stuck | (run & sys_reset_n & (cnt_q < HI));
  // Sensing scheme feeds inverted reset, gated by the controller line
  assign keep_alive_in = run & (sense ? !sys_reset_n : sys_reset_n);
endmodule // wkp_mcu
`default_nettype wire

// >>> verif/watchdog_and_keepalive_power_control_test.sv
/* Bench for wkp_top with controller model.
 Counts shrunk by parameter. */
`timescale 1ns/1ns
`default_nettype none
module watchdog_and_keepalive_power_control_test;
  localparam integer WD = 200;
  localparam integer DL = 200;
  logic       clk, reset, on_off_in, wd_strap_disable_in, main_in_reg, run, stuck, sense;
  logic [7:0] per = 8'h64;
  wire        wd_trigger_in, keep_alive_in, out_enable, sys_reset_n, wd_disabled;
  int         n_errors = 0, comparisons = 0, n;
  wkp_top #(.WD_TERM_CYC(WD), .WD_START_CYC(5), .DLY_TERM_CYC(DL),
    .DLY_START_CYC(5), .TRIG_MIN_CYC(4)) u_wkp_top (.*);
  wkp_mcu u_wkp_mcu (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========
  // Tasks and tests
  function logic en_exp(logic a, logic b);
    return a | b;
  endfunction
  task test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic e, input logic g);
    comparisons++;
    n_errors += (g !== e);
    if (g !== e) $display("[ERR] %s exp %b got %b", nm, e, g);
  endtask
  task wrn(input logic v, input int lim);
    for (n = 0; sys_reset_n !== v && n < lim; n++) @(negedge clk);
    chk("reset_wait", v, sys_reset_n);
    if (sys_reset_n !== v) test_done();
  endtask
  task hold(input int k);
    n = 0;
    repeat (k) @(negedge clk) n += (sys_reset_n !== 1'b1);
  endtask
  initial begin
    {reset, main_in_reg, on_off_in, wd_strap_disable_in, run, stuck, sense} = 7'h60;
    n = $urandom(35405);
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("oe", 1'b0, out_enable);
    chk("rn", 1'b0, sys_reset_n);
    @(posedge clk) on_off_in <= 1'b1;
    wrn(1'b1, DL + 60);
    chk("dly", 1'b1, n >= DL);
    wrn(1'b0, WD + 60);
    chk("wd", 1'b1, n >= WD);
    wrn(1'b1, DL + 60);
    chk("wdly", 1'b1, n >= DL);
    $display("test cycling done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {run, per} <= {1'b1, 8'h28 + 8'($urandom % 32'h50)};
      hold(300);
      chk("refresh", 1'b0, n != 0);
    end
    @(posedge clk) stuck <= 1'b1;
    wrn(1'b0, WD + 60);
    @(posedge clk) stuck <= 1'b0;
    wrn(1'b1, DL + 60);
    $display("test trigger done");
    @(posedge clk) on_off_in <= 1'b0;
    hold(50);
    chk("ka_on", en_exp(on_off_in, keep_alive_in), out_enable);
    @(posedge clk) run <= 1'b0;
    repeat (8) @(negedge clk);
    chk("ka_off", en_exp(on_off_in, keep_alive_in), out_enable);
    chk("off_rn", 1'b0, sys_reset_n);
    $display("test keep-alive done");
    @(posedge clk) on_off_in <= 1'b1;
    wrn(1'b1, DL + 60);
    @(posedge clk) main_in_reg <= 1'b0;
    repeat (6) @(negedge clk);
    chk("mon", 1'b0, sys_reset_n);
    @(posedge clk) {main_in_reg, wd_strap_disable_in} <= 2'h3;
    wrn(1'b1, DL + 60);
    chk("strap", 1'b1, wd_disabled);
    hold(WD * 3);
    chk("no_wd", 1'b0, n != 0);
    $display("test supply and strap done");
    @(posedge clk) {sense, run, on_off_in} <= 3'h6;
    wrn(1'b0, 20);
    wrn(1'b1, DL + 60);
    chk("sense_dly", 1'b1, n >= DL);
    wrn(1'b0, 20);
    @(posedge clk) run <= 1'b0;
    n = 0;
    repeat (DL + 60) @(negedge clk) n += sys_reset_n;
    chk("sense_off", 1'b0, n != 0);
    chk("sense_oe", 1'b0, out_enable);
    $display("test sensing done");
    test_done();
  end
endmodule // watchdog_and_keepalive_power_control_test
`default_nettype wire
